// ===== core/asp_defs.svh
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ASP_OFS_FMT 16'h7050
`define ASP_OFS_CTL1 16'h7051
`define ASP_OFS_BAUDH 16'h7052
`define ASP_OFS_BAUDL 16'h7053
`define ASP_OFS_CTL2 16'h7054
`define ASP_OFS_RXST 16'h7055
`define ASP_OFS_RXEMU 16'h7056
`define ASP_OFS_RXBUF 16'h7057
`define ASP_OFS_TXBUF 16'h7059
// ----------------------------------------
// field positions
// ----------------------------------------
`define ASP_FMT_STOP 7
`define ASP_FMT_EVEN 6
`define ASP_FMT_PAREN 5
`define ASP_FMT_ADDRMODE 3
`define ASP_CTL1_ERRIE 6
`define ASP_CTL1_SWRST 5
`define ASP_CTL1_CLKEN 4
`define ASP_CTL1_TRANSMIT_WAKE_REQUEST 3
`define ASP_CTL1_SLEEP 2
`define ASP_CTL1_TXEN 1
`define ASP_CTL1_RXEN 0
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define ASP_RST_BYTE 8'h00
`define ASP_IDLE_BITS 4'hB
`define ASP_ZERO_DIV 16'h0001
`endif

// ===== core/asp_pkg.sv
// ----------------------------------------
// types
// ----------------------------------------
package asp_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_GAP = 3'b001,
    TX_START = 3'b010,
    TX_DATA = 3'b011,
    TX_ADDR = 3'b100,
    TX_PAR = 3'b101,
    TX_STOP = 3'b110
  } asp_tx_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asp_bus_req_t;
endpackage : asp_pkg

// ===== core/async_serial_port.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "asp_defs.svh"
// What this block does
// - transmit one or two stop bits per stop bit; receiver checks one stop bit
// - parity sense: odd at 0, even at 1, on transmit and receive
// - parity enable switches parity; address bit counts in parity when on
// - unused upper bits of short characters are left out of parity
// - parity off means no parity bit sent or expected
// - protocol select: idle-line at 0, address-bit with extra bit at 1
// - character length is length field plus one, 1 to 8 bits
// - short characters right-justified, upper bits zero in main receive buffer
// - error interrupt requested while error summary set and enable high
// - soft reset low clears state machines and receive flags, sets transmit flags
// - soft reset leaves configuration bits untouched
// - logic stays in reset while soft reset bit is zero
// - clock enable bit selects internal serial clock onto serial clock pin
// - idle-line wake plus buffer write sends eleven idle bits first
// - address-bit wake plus buffer write sets frame address bit
// - transmit wake is set-only, cleared by reset or transfer to wake temp
// - sleep suppresses ready and error flags until an address is seen
// - transmitter drives only while enabled, finishing written data first
// - receiver enable gates buffer transfers and interrupts, shifter keeps going
// - baud is clock over (divisor+1)*8, or over 16 for divisor zero
module async_serial_port (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire asp_pkg::asp_bus_req_t busReq,
  output logic [7:0] rdData,
  // serial pins
  input wire logic receivePin,
  output logic transmitPin,
  output logic serialClockPin,
  output logic serialClockOe,
  // interrupt requests
  output logic rxFaultIrq
);
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] fmt_q;
  logic [7:0] ctl1_q;
  logic [15:0] baud_q;
  logic [1:0] ctl2En_q;
  logic [7:0] txBuf_q;
  logic txFull_q;
  logic txBufWake_q;
  logic wakeTemp_q;
  logic txBufEn_q;
  logic txLoad;
  logic [7:0] rxBuf_q;
  logic [7:0] rxEmu_q;
  logic receive_ready_flag_q, brk_q, fe_q, oe_q, pe_q, receive_wake_flag_q;
  // decoded requests
  wire wrFmt = busReq.wr && busReq.addr == `ASP_OFS_FMT;
  wire wrCtl1 = busReq.wr && busReq.addr == `ASP_OFS_CTL1;
  wire wrTx = busReq.wr && busReq.addr == `ASP_OFS_TXBUF;
  wire rdRxBuf = busReq.rd && busReq.addr == `ASP_OFS_RXBUF;
  wire wrBaudH = busReq.wr && busReq.addr == `ASP_OFS_BAUDH;
  wire wrBaudL = busReq.wr && busReq.addr == `ASP_OFS_BAUDL;
  wire wrCtl2 = busReq.wr && busReq.addr == `ASP_OFS_CTL2;
  // wake bit is set-only; a software set wins over the load clear
  wire wakeNext = (ctl1_q[`ASP_CTL1_TRANSMIT_WAKE_REQUEST] && !txLoad) || busReq.wdata[`ASP_CTL1_TRANSMIT_WAKE_REQUEST];
  wire swRun = ctl1_q[`ASP_CTL1_SWRST];
  wire [3:0] charLen = {1'b0, fmt_q[2:0]} + 4'h1;
  wire parOn = fmt_q[`ASP_FMT_PAREN];
  wire addrMode = fmt_q[`ASP_FMT_ADDRMODE];
  wire [7:0] lenMask = 8'hFF >> (4'h8 - charLen);
  // parity of masked data plus optional address bit, sense applied
  function automatic logic parBit(input logic [7:0] d, input logic [7:0] m, input logic a, input logic even);
    parBit = ^(d & m) ^ a ^ ~even;
  endfunction : parBit
  // ----------------------------------------
  // baud divider
  // ----------------------------------------
  logic [15:0] divCnt_q;
  logic [2:0] sub_q;
  logic bitTick;
  wire [15:0] divTop = (baud_q == 16'h0000) ? `ASP_ZERO_DIV : baud_q;
  wire divWrap = divCnt_q == divTop;
  // eight sub-ticks per bit; divisor zero runs at the /16 rate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= 16'h0000;
      sub_q <= 3'h0;
    end else if (!swRun || divWrap) begin
      divCnt_q <= 16'h0000;
      sub_q <= swRun ? sub_q + 3'h1 : 3'h0;
    end else begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end
  wire subTick = swRun && divWrap;
  assign bitTick = subTick && sub_q == 3'h7;
  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_q <= `ASP_RST_BYTE;
      ctl1_q <= `ASP_RST_BYTE;
      baud_q <= 16'h0000;
      ctl2En_q <= 2'h0;
    end else begin
      if (wrFmt) fmt_q <= busReq.wdata;
      if (wrCtl1) ctl1_q <= {1'b0, busReq.wdata[6:4], wakeNext, busReq.wdata[2:0]};
      else if (txLoad) ctl1_q[`ASP_CTL1_TRANSMIT_WAKE_REQUEST] <= 1'b0;
      // divisor bytes pair into one 16-bit value
      if (wrBaudH) baud_q[15:8] <= busReq.wdata;
      if (wrBaudL) baud_q[7:0] <= busReq.wdata;
      if (wrCtl2) ctl2En_q <= busReq.wdata[1:0];
    end
  end
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  asp_pkg::asp_tx_state_t txSt_q;
  logic [7:0] txSh_q;
  logic [3:0] txCnt_q;
  logic txPar_q;
  // a character written while enabled still goes out after the enable drops
  assign txLoad = txSt_q == asp_pkg::TX_IDLE && txFull_q && (ctl1_q[`ASP_CTL1_TXEN] || txBufEn_q) && bitTick;
  // buffer holds one character and latches the wake request and the enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txBuf_q <= `ASP_RST_BYTE;
      txFull_q <= 1'b0;
      txBufWake_q <= 1'b0;
      txBufEn_q <= 1'b0;
    end else if (!swRun) begin
      txFull_q <= 1'b0;
    end else if (wrTx) begin
      txBuf_q <= busReq.wdata;
      txFull_q <= 1'b1;
      txBufWake_q <= ctl1_q[`ASP_CTL1_TRANSMIT_WAKE_REQUEST];
      txBufEn_q <= ctl1_q[`ASP_CTL1_TXEN];
    end else if (txLoad) begin
      txFull_q <= 1'b0;
    end
  end
  // frame sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txSt_q <= asp_pkg::TX_IDLE;
      txSh_q <= 8'h00;
      txCnt_q <= 4'h0;
      txPar_q <= 1'b0;
      wakeTemp_q <= 1'b0;
      transmitPin <= 1'b1;
    end else if (!swRun) begin
      txSt_q <= asp_pkg::TX_IDLE;
      transmitPin <= 1'b1;
    end else if (txLoad) begin
      txSh_q <= txBuf_q;
      wakeTemp_q <= txBufWake_q;
      txPar_q <= parBit(txBuf_q, lenMask, addrMode & txBufWake_q, fmt_q[`ASP_FMT_EVEN]);
      txCnt_q <= 4'h0;
      if (!addrMode && txBufWake_q) begin
        txSt_q <= asp_pkg::TX_GAP;
        transmitPin <= 1'b1;
      end else begin
        txSt_q <= asp_pkg::TX_START;
        transmitPin <= 1'b0;
      end
    end else if (bitTick) begin
      case (txSt_q)
        asp_pkg::TX_GAP: begin
          if (txCnt_q == `ASP_IDLE_BITS - 4'h1) begin
            txSt_q <= asp_pkg::TX_START;
            txCnt_q <= 4'h0;
            transmitPin <= 1'b0;
          end else begin
            txCnt_q <= txCnt_q + 4'h1;
          end
        end
        asp_pkg::TX_START, asp_pkg::TX_DATA: begin
          if (txSt_q == asp_pkg::TX_DATA && txCnt_q == charLen) begin
            txCnt_q <= 4'h0;
            if (addrMode) begin
              txSt_q <= asp_pkg::TX_ADDR;
              transmitPin <= wakeTemp_q;
            end else if (parOn) begin
              txSt_q <= asp_pkg::TX_PAR;
              transmitPin <= txPar_q;
            end else begin
              txSt_q <= asp_pkg::TX_STOP;
              transmitPin <= 1'b1;
            end
          end else begin
            txSt_q <= asp_pkg::TX_DATA;
            transmitPin <= txSh_q[0];
            txSh_q <= {1'b0, txSh_q[7:1]};
            txCnt_q <= txCnt_q + 4'h1;
          end
        end
        asp_pkg::TX_ADDR: begin
          txSt_q <= parOn ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
          transmitPin <= parOn ? txPar_q : 1'b1;
        end
        asp_pkg::TX_PAR: begin
          txSt_q <= asp_pkg::TX_STOP;
          transmitPin <= 1'b1;
        end
        asp_pkg::TX_STOP: begin
          if (txCnt_q == {3'h0, fmt_q[`ASP_FMT_STOP]}) begin
            txSt_q <= asp_pkg::TX_IDLE;
            txCnt_q <= 4'h0;
          end else begin
            txCnt_q <= txCnt_q + 4'h1;
          end
        end
        default: txSt_q <= asp_pkg::TX_IDLE;
      endcase
    end
  end
  wire txEmpty = !txFull_q && txSt_q == asp_pkg::TX_IDLE;
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic rxS1_q, rxS2_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxS1_q <= 1'b1;
      rxS2_q <= 1'b1;
    end else begin
      rxS1_q <= receivePin;
      rxS2_q <= rxS1_q;
    end
  end
  logic rxBusy_q;
  logic [2:0] rxSub_q;
  logic [3:0] rxCnt_q;
  logic [7:0] rxSh_q;
  logic rxAddr_q;
  logic rxParAcc_q;
  logic [3:0] lowBits_q;
  wire [3:0] rxFrameLen = charLen + {3'h0, addrMode} + {3'h0, parOn};
  wire rxMid = rxBusy_q && subTick && rxSub_q == 3'h3;
  wire rxDone = rxMid && rxCnt_q == rxFrameLen + 4'h1;
  wire stopBad = rxDone && !rxS2_q;
  wire parBad = parOn && (rxParAcc_q ^ ~fmt_q[`ASP_FMT_EVEN]);
  wire awake = !ctl1_q[`ASP_CTL1_SLEEP] || (addrMode ? rxAddr_q : lowBits_q >= `ASP_IDLE_BITS - 4'h1);
  wire rxDeliver = rxDone && rxS2_q && ctl1_q[`ASP_CTL1_RXEN] && !brk_q && awake;
  wire brkSeen = rxBusy_q && subTick && rxSub_q == 3'h3 && lowBits_q == 4'hF;
  // shifter samples mid-bit and runs whatever the enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxBusy_q <= 1'b0;
      rxSub_q <= 3'h0;
      rxCnt_q <= 4'h0;
      rxSh_q <= 8'h00;
      rxAddr_q <= 1'b0;
      rxParAcc_q <= 1'b0;
      lowBits_q <= 4'h0;
    end else if (!swRun) begin
      rxBusy_q <= 1'b0;
      lowBits_q <= 4'h0;
    end else if (!rxBusy_q) begin
      if (!rxS2_q) begin
        rxBusy_q <= 1'b1;
        rxSub_q <= 3'h0;
        rxCnt_q <= 4'h0;
        rxSh_q <= 8'h00;
        rxParAcc_q <= 1'b0;
      end else if (bitTick && lowBits_q != 4'hF) begin
        lowBits_q <= lowBits_q + 4'h1;
      end
    end else if (subTick) begin
      rxSub_q <= rxSub_q + 3'h1;
      if (rxSub_q == 3'h3) begin
        rxCnt_q <= rxCnt_q + 4'h1;
        if (rxCnt_q >= 4'h1 && rxCnt_q <= charLen) begin
          rxSh_q[rxCnt_q[2:0] - 3'h1] <= rxS2_q;
          rxParAcc_q <= rxParAcc_q ^ rxS2_q;
        end else if (addrMode && rxCnt_q == charLen + 4'h1) begin
          rxAddr_q <= rxS2_q;
          rxParAcc_q <= rxParAcc_q ^ rxS2_q;
        end else if (rxCnt_q != 4'h0 && rxCnt_q <= rxFrameLen) begin
          rxParAcc_q <= rxParAcc_q ^ rxS2_q;
        end
        if (rxDone) begin
          rxBusy_q <= 1'b0;
          lowBits_q <= 4'h0;
        end
      end
    end
  end
  // status flags; hardware set wins over a read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {receive_ready_flag_q, brk_q, fe_q, oe_q, pe_q, receive_wake_flag_q} <= 6'h00;
      rxBuf_q <= 8'h00;
      rxEmu_q <= 8'h00;
    end else if (!swRun) begin
      {receive_ready_flag_q, brk_q, fe_q, oe_q, pe_q, receive_wake_flag_q} <= 6'h00;
    end else begin
      if (rdRxBuf) receive_ready_flag_q <= 1'b0;
      if (stopBad && ctl1_q[`ASP_CTL1_RXEN] && awake) fe_q <= 1'b1;
      if (brkSeen && fe_q) brk_q <= 1'b1;
      if (rxDeliver) begin
        rxBuf_q <= rxSh_q & lenMask;
        rxEmu_q <= rxSh_q;
        receive_ready_flag_q <= 1'b1;
        receive_wake_flag_q <= addrMode ? rxAddr_q : lowBits_q >= `ASP_IDLE_BITS - 4'h1;
        if (receive_ready_flag_q && !rdRxBuf) oe_q <= 1'b1;
        if (parBad) pe_q <= 1'b1;
      end
    end
  end
  wire rxErr = brk_q | fe_q | oe_q | pe_q;
  // ----------------------------------------
  // read mux and outputs
  // ----------------------------------------
  wire [7:0] rdMux =
    busReq.addr == `ASP_OFS_FMT ? fmt_q :
    busReq.addr == `ASP_OFS_CTL1 ? {1'b0, ctl1_q[6:0]} :
    busReq.addr == `ASP_OFS_BAUDH ? baud_q[15:8] :
    busReq.addr == `ASP_OFS_BAUDL ? baud_q[7:0] :
    busReq.addr == `ASP_OFS_CTL2 ? {!txFull_q || !swRun, txEmpty || !swRun, 4'h0, ctl2En_q} :
    busReq.addr == `ASP_OFS_RXST ? {rxErr, receive_ready_flag_q, brk_q, fe_q, oe_q, pe_q, receive_wake_flag_q, 1'b0} :
    busReq.addr == `ASP_OFS_RXEMU ? rxEmu_q :
    busReq.addr == `ASP_OFS_RXBUF ? rxBuf_q : 8'h00;
  // read data stand one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
      rxFaultIrq <= 1'b0;
      serialClockPin <= 1'b0;
      serialClockOe <= 1'b0;
    end else begin
      rdData <= busReq.rd ? rdMux : 8'h00;
      rxFaultIrq <= rxErr && ctl1_q[`ASP_CTL1_ERRIE] && ctl1_q[`ASP_CTL1_RXEN];
      serialClockOe <= ctl1_q[`ASP_CTL1_CLKEN];
      serialClockPin <= ctl1_q[`ASP_CTL1_CLKEN] && sub_q[2];
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  irq_gate_a: assert property (rxFaultIrq |-> $past(ctl1_q[`ASP_CTL1_ERRIE])) else $error("irq without enable");
  irq_set_a: assert property (rxErr && ctl1_q[6] && ctl1_q[0] |=> rxFaultIrq) else $error("irq missing");
  soft_clear_a: assert property (!swRun |=> !receive_ready_flag_q && !fe_q && !oe_q && !pe_q && !brk_q) else $error("flags not cleared");
  soft_idle_a: assert property (!swRun |=> txSt_q == asp_pkg::TX_IDLE && transmitPin) else $error("tx not held");
  cfg_keep_a: assert property (!wrFmt |=> $stable(fmt_q)) else $error("format changed");
  wake_hold_a: assert property ($past(ctl1_q[3]) && !$past(txLoad) |-> ctl1_q[3]) else $error("wake cleared early");
  start_low_a: assert property (txSt_q == asp_pkg::TX_START |-> !transmitPin) else $error("start not low");
  stop_high_a: assert property (txSt_q == asp_pkg::TX_STOP |-> transmitPin) else $error("stop not high");
  no_par_a: assert property (!parOn |-> txSt_q != asp_pkg::TX_PAR) else $error("parity when off");
  rx_gate_a: assert property (!ctl1_q[0] |=> !$rose(receive_ready_flag_q)) else $error("ready while disabled");
  buf_mask_a: assert property (rxDeliver |=> (rxBuf_q & ~lenMask) == 8'h00) else $error("upper bits set");
  load_en_a: assert property (txLoad |-> ctl1_q[1] || txBufEn_q) else $error("load while disabled");
  // transmit frame shape
  data_len_a: assert property (txSt_q == asp_pkg::TX_DATA |-> txCnt_q <= charLen) else $error("data overrun");
  stop_cnt_a: assert property (txSt_q == asp_pkg::TX_STOP |-> txCnt_q <= {3'h0, fmt_q[7]})
    else $error("stop overrun");
  addr_only_a: assert property (!addrMode |-> txSt_q != asp_pkg::TX_ADDR) else $error("address bit in idle mode");
  gap_len_a: assert property (txSt_q == asp_pkg::TX_GAP && bitTick && txCnt_q == `ASP_IDLE_BITS - 4'h1
    |=> txSt_q == asp_pkg::TX_START) else $error("gap not eleven bits");
  // receive side, then transmit and receive covers
  sleep_gate_a: assert property (ctl1_q[2] && !awake |=> !$rose(receive_ready_flag_q)) else $error("ready while asleep");
  tx_frame_c: cover property (txSt_q == asp_pkg::TX_STOP ##1 txSt_q == asp_pkg::TX_IDLE);
  tx_gap_c: cover property (txSt_q == asp_pkg::TX_GAP);
  rx_char_c: cover property (rxDeliver);
  rx_err_c: cover property (rxFaultIrq);
  rx_sleep_c: cover property (ctl1_q[2] && rxDeliver);
endmodule : async_serial_port

// ===== testbench/asp_remote_node.sv
`timescale 1ns/1ps
// ----------------------------------------
// remote serial node
// ----------------------------------------
module asp_remote_node #(
  parameter int BIT = 16
) (
  // clock
  input wire logic mclk,
  // serial lines
  input wire logic lineIn,
  output logic lineOut
);
  // line idles high between frames
  initial lineOut = 1'b1;

  // step n clock edges, then let that edge's updates land
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // drive n frame bits, first bit first, one bit time each
  task automatic send_frame(input logic [15:0] bits, input int n);
    tick(1);
    for (int i = 0; i < n; i++) begin
      lineOut <= bits[i];
      tick(BIT);
    end
    lineOut <= 1'b1;
  endtask : send_frame

  // wait for a start bit, then sample n bits at mid-bit; waited counts cycles to the start
  task automatic get_frame(output logic [15:0] bits, output int waited, input int n);
    bits = '1; // bits past the frame read as idle line
    waited = 0;
    while (lineIn !== 1'b0 && waited < 4000) begin
      tick(1);
      waited++;
    end
    tick(BIT / 2);
    for (int i = 0; i < n; i++) begin
      bits[i] = lineIn;
      tick(BIT);
    end
  endtask : get_frame
endmodule : asp_remote_node

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`include "asp_defs.svh"
// ----------------------------------------
// top-level bench
// ----------------------------------------
module tb_top;
  localparam int BIT = 16;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  asp_pkg::asp_bus_req_t busReq = '0;
  logic [7:0] rdData;
  logic txLine;
  logic rxLine;
  logic sclk;
  logic sclkOe;
  logic rxFaultIrq;
  int error_cnt = 0;
  int comparisons = 0;
  logic [19:0] fr;
  logic [15:0] got;
  int w;
  int hi;
  // rows: format, transmit data, expected receive buffer
  logic [23:0] rows [9] = '{24'h17A5A5, 24'h10FF01, 24'h310303, 24'h720505, 24'hB33C0C,
    24'h341B1B, 24'h1D2A2A, 24'h7E5555, 24'hF78181};

  // 100 MHz clock
  always #5 mclk = ~mclk;

  async_serial_port async_serial_port_inst (
    .mclk(mclk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData), .receivePin(rxLine),
    .transmitPin(txLine), .serialClockPin(sclk), .serialClockOe(sclkOe), .rxFaultIrq(rxFaultIrq)
  );
  asp_remote_node #(.BIT(BIT)) asp_remote_node_inst (.mclk(mclk), .lineIn(txLine), .lineOut(rxLine));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    busReq <= '0;
  endtask : wr

  // read one register and compare the masked value
  task automatic rchk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    busReq <= '0;
    #1;
    check({8'h00, rdData & m}, {8'h00, e});
  endtask : rchk

  // count cycles with the transmit line away from idle
  task automatic quiet(input int c);
    int lows;
    lows = 0;
    repeat (c) begin
      tick(1);
      lows += int'(txLine !== 1'b1);
    end
    check(16'(lows), 16'h0000);
  endtask : quiet

  // expected frame {bit count, bits} for format f, data d, address bit a
  function automatic logic [19:0] mk(input logic [7:0] f, input logic [7:0] d, input logic a);
    logic [15:0] b;
    logic [7:0] m;
    int n;
    b = 16'hFFFF;
    b[0] = 1'b0;
    n = 1;
    m = 8'hFF >> (3'h7 - f[2:0]);
    for (int i = 0; i <= int'(f[2:0]); i++) b[n++] = d[i];
    if (f[3]) b[n++] = a;
    if (f[5]) b[n++] = (^(d & m)) ^ (a & f[3]) ^ !f[6];
    n += 1 + int'(f[7]);
    return {4'(n), b};
  endfunction : mk

  task automatic print_verdict;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // watchdog
  initial begin
    tick(30000);
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(1);
    check({14'h0, sclkOe, txLine}, 16'h0001);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(`ASP_OFS_FMT, 8'hFF, 8'h00);
    rchk(`ASP_OFS_CTL1, 8'hFF, 8'h00);
    rchk(`ASP_OFS_CTL2, 8'hC0, 8'hC0);
    rchk(16'h7058, 8'hFF, 8'h00);
    wr(`ASP_OFS_FMT, 8'h17);
    wr(`ASP_OFS_CTL1, 8'h02);
    wr(`ASP_OFS_TXBUF, 8'h55);
    quiet(400);
    wr(`ASP_OFS_CTL1, 8'h23);
    quiet(400);
    // ordinary frames in both directions
    for (int r = 0; r < 9; r++) begin
      wr(`ASP_OFS_CTL1, 8'h00);
      wr(`ASP_OFS_FMT, rows[r][23:16]);
      wr(`ASP_OFS_CTL1, 8'h23);
      fr = mk(rows[r][23:16], rows[r][15:8], 1'b0);
      wr(`ASP_OFS_TXBUF, rows[r][15:8]);
      asp_remote_node_inst.get_frame(got, w, int'(fr[19:16]));
      check(got, fr[15:0]);
      asp_remote_node_inst.send_frame(fr[15:0], int'(fr[19:16]) - int'(rows[r][23]));
      rchk(`ASP_OFS_RXST, 8'hFC, 8'h40);
      rchk(`ASP_OFS_RXEMU, 8'hFF, rows[r][7:0]);
      rchk(`ASP_OFS_RXBUF, 8'hFF, rows[r][7:0]);
    end
    // idle-line wake with the transmitter switched off behind the write
    wr(`ASP_OFS_CTL1, 8'h00);
    wr(`ASP_OFS_FMT, 8'h17);
    wr(`ASP_OFS_CTL1, 8'h2B);
    wr(`ASP_OFS_TXBUF, 8'hC3);
    wr(`ASP_OFS_CTL1, 8'h21);
    fr = mk(8'h17, 8'hC3, 1'b0);
    asp_remote_node_inst.get_frame(got, w, int'(fr[19:16]));
    check(got, fr[15:0]);
    check({15'h0, (w >= 11 * BIT - 8) && (w < 13 * BIT)}, 16'h0001);
    rchk(`ASP_OFS_CTL1, 8'hFF, 8'h21);
    wr(`ASP_OFS_TXBUF, 8'h0F);
    quiet(400);
    // address-bit wake, set-only wake bit
    wr(`ASP_OFS_CTL1, 8'h08);
    wr(`ASP_OFS_FMT, 8'h1F);
    wr(`ASP_OFS_CTL1, 8'h23);
    rchk(`ASP_OFS_CTL1, 8'hFF, 8'h2B);
    fr = mk(8'h1F, 8'h66, 1'b1);
    wr(`ASP_OFS_TXBUF, 8'h66);
    asp_remote_node_inst.get_frame(got, w, int'(fr[19:16]));
    check(got, fr[15:0]);
    // receive sleep until an address frame
    wr(`ASP_OFS_CTL1, 8'h04);
    wr(`ASP_OFS_CTL1, 8'h25);
    fr = mk(8'h1F, 8'h66, 1'b0);
    asp_remote_node_inst.send_frame(fr[15:0], int'(fr[19:16]));
    rchk(`ASP_OFS_RXST, 8'h40, 8'h00);
    fr = mk(8'h1F, 8'h77, 1'b1);
    asp_remote_node_inst.send_frame(fr[15:0], int'(fr[19:16]));
    rchk(`ASP_OFS_RXST, 8'h40, 8'h40);
    rchk(`ASP_OFS_CTL1, 8'h04, 8'h04);
    // receiver enable off, then set in mid-character
    wr(`ASP_OFS_CTL1, 8'h00);
    wr(`ASP_OFS_CTL1, 8'h20);
    fr = mk(8'h1F, 8'h99, 1'b0);
    asp_remote_node_inst.send_frame(fr[15:0], int'(fr[19:16]));
    rchk(`ASP_OFS_RXST, 8'h40, 8'h00);
    fork
      asp_remote_node_inst.send_frame(fr[15:0], int'(fr[19:16]));
      begin
        tick(3 * BIT);
        wr(`ASP_OFS_CTL1, 8'h21);
      end
    join
    rchk(`ASP_OFS_RXST, 8'h40, 8'h40);
    rchk(`ASP_OFS_RXBUF, 8'hFF, 8'h99);
    // parity fault, error request, then soft reset
    wr(`ASP_OFS_CTL1, 8'h00);
    wr(`ASP_OFS_FMT, 8'h37);
    wr(`ASP_OFS_CTL1, 8'h21);
    fr = mk(8'h37, 8'h5A, 1'b0);
    asp_remote_node_inst.send_frame(fr[15:0] ^ 16'h0200, int'(fr[19:16]));
    check({15'h0, rxFaultIrq}, 16'h0000);
    rchk(`ASP_OFS_RXST, 8'hBC, 8'h84);
    wr(`ASP_OFS_CTL1, 8'h71);
    tick(2);
    check({14'h0, rxFaultIrq, sclkOe}, 16'h0003);
    hi = 0;
    repeat (32) begin
      tick(1);
      hi += int'(sclk);
    end
    check({15'h0, hi > 0 && hi < 32}, 16'h0001);
    wr(`ASP_OFS_CTL1, 8'h51);
    tick(2);
    check({14'h0, rxFaultIrq, sclkOe}, 16'h0001);
    rchk(`ASP_OFS_RXST, 8'hFE, 8'h00);
    rchk(`ASP_OFS_CTL2, 8'hC0, 8'hC0);
    rchk(`ASP_OFS_FMT, 8'hFF, 8'h37);
    asp_remote_node_inst.send_frame(fr[15:0] ^ 16'h0200, int'(fr[19:16]));
    rchk(`ASP_OFS_RXST, 8'hFE, 8'h00);
    print_verdict();
  end
endmodule : tb_top
